/* rtl/zcd_top.sv */
// Zero crossing detector logic with AHB-Lite registers and interrupt.
`timescale 1ns/1ps
`default_nettype none
module zcd_top
  import zcd_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog front end and fuse.
  input wire logic comp_above_ref,
  input wire logic cfg_fuse,
  output logic sink_active,
  output logic source_active,
  output logic detector_active,
  output logic pullup_request,
  // Internal result and interrupt.
  output logic crossing_out,
  output logic irq
);
  // Register map, one aligned word each: control at its index times four, then
  // status, clear, enable and pin configuration in the low words. Status, clear
  // and enable share one layout: bit 0 is the crossing flag, bit 1 the invert
  // change. Clear is write-one-to-clear and reads zero; address bits above the
  // decoded range are ignored, so the map repeats through the bus window.
  // Control fields.
  logic detector_sw_enable_q;
  logic result_invert_q;
  logic rise_irq_en_q;
  logic fall_irq_en_q;
  logic pullup_q;
  logic invert_prev_q;
  logic fuse_q;
  logic fuse_meta_q;
  // Event status and enable.
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] enable_q;
  logic [EVT_W-1:0] set_evt;
  logic [EVT_W-1:0] clr_evt;
  // Bus data phase tracking and the write strobes decoded from it.
  logic wr_pend_q;
  logic [ADDR_W-1:0] addr_q;
  logic ctrl_wr;
  logic clear_wr;
  logic enable_wr;
  logic pincfg_wr;
  // Crossing path.
  logic comp_sync;
  logic adjusted;
  logic active;
  logic rise;
  logic fall;
  logic addr_phase;

  // True when the given byte address is one of the mapped registers.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_CLEAR) ||
             (a == ADDR_ENABLE) || (a == ADDR_PINCFG);
  endfunction : mapped

  // True when the pending data phase writes the given register.
  function automatic logic write_to(input logic pend, input logic [ADDR_W-1:0] at,
                                    input logic [ADDR_W-1:0] target);
    write_to = pend && (at == target);
  endfunction : write_to

  // Read value of one register; write-only and unmapped words read zero.
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    read_word = '0;
    if (mapped(a))
    begin
      case (a)
        ADDR_CTRL:
        begin
          read_word[BIT_SW_EN] = detector_sw_enable_q;
          read_word[BIT_RESULT] = adjusted;
          read_word[BIT_INVERT] = result_invert_q;
          read_word[BIT_RISE_EN] = rise_irq_en_q;
          read_word[BIT_FALL_EN] = fall_irq_en_q;
        end
        ADDR_STATUS: read_word[EVT_W-1:0] = status_q;
        ADDR_ENABLE: read_word[EVT_W-1:0] = enable_q;
        ADDR_PINCFG: read_word[BIT_PULLUP] = pullup_q;
        default: read_word = '0;
      endcase
    end
  endfunction : read_word

  // Comparator result is asynchronous to the system clock. Two stages cost two
  // clocks of latency, which is negligible against a mains half period.
  zcd_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .async_in(comp_above_ref),
    .sync_out(comp_sync)
  );

  // Fuse pin is a strap from outside; caught through two flops.
  // The flops reset to the inactive setting, so the pin is not driven for the
  // two clocks after reset before the real strap level has been sampled.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fuse_meta_q <= 1'b1;
      fuse_q <= 1'b1;
    end
    else if (ce)
    begin
      fuse_meta_q <= cfg_fuse;
      fuse_q <= fuse_meta_q;
    end
  end

  // Fuse low forces the detector on and the software enable is ignored.
  // With the fuse set, clearing the software enable hands the pin back to
  // ordinary port control.
  assign active = !fuse_q || detector_sw_enable_q;

  // High comparator means sink; inversion flips the readable sense.
  assign adjusted = comp_sync ^ result_invert_q;

  // Edges look at the adjusted result, so inversion picks the transition.
  zcd_edge u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .level(adjusted),
    .rise(rise),
    .fall(fall)
  );

  // Pin drive. Only one of sink and source may be on at a time; both rest when
  // the detector is off so the pin falls back to ordinary port control.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sink_active <= 1'b0;
      source_active <= 1'b0;
      detector_active <= 1'b0;
    end
    else if (ce)
    begin
      sink_active <= active && comp_sync;
      source_active <= active && !comp_sync;
      detector_active <= active;
    end
  end

  // Shared result for other peripherals; it follows the readable bit one clock later.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      crossing_out <= 1'b0;
    else if (ce)
      crossing_out <= adjusted;
  end

  // Pull-up request to the pad; software is expected to keep it off.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pullup_request <= 1'b0;
    else if (ce)
      pullup_request <= pullup_q;
  end

  // Address phase is taken when the bus is ready, we are selected and a nonsequential word transfer is requested.
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ) &&
                      (hsize == HSIZE_WORD);

  // Data phase bookkeeping. The slave inserts no wait states: an address phase taken
  // at one edge is followed by a data phase that closes at the next edge, and a write
  // lands at that closing edge with the data the master puts on in between.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= '0;
    end
    else if (ce)
    begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase)
        addr_q <= haddr[ADDR_W-1:0];
    end
  end

  // One strobe per writable register, decoded once from the pending data phase.
  assign ctrl_wr = write_to(wr_pend_q, addr_q, ADDR_CTRL);
  assign clear_wr = write_to(wr_pend_q, addr_q, ADDR_CLEAR);
  assign enable_wr = write_to(wr_pend_q, addr_q, ADDR_ENABLE);
  assign pincfg_wr = write_to(wr_pend_q, addr_q, ADDR_PINCFG);

  // The slave never stalls and always answers OKAY.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control register fields, written at the close of the data phase.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      detector_sw_enable_q <= CTRL_RESET[BIT_SW_EN];
      result_invert_q <= CTRL_RESET[BIT_INVERT];
      rise_irq_en_q <= CTRL_RESET[BIT_RISE_EN];
      fall_irq_en_q <= CTRL_RESET[BIT_FALL_EN];
    end
    else if (ce && ctrl_wr)
    begin
      detector_sw_enable_q <= hwdata[BIT_SW_EN];
      result_invert_q <= hwdata[BIT_INVERT];
      rise_irq_en_q <= hwdata[BIT_RISE_EN];
      fall_irq_en_q <= hwdata[BIT_FALL_EN];
    end
  end

  // Pin configuration; the pull-up fights the source and sink, so software owns it.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pullup_q <= 1'b0;
    else if (ce && pincfg_wr)
      pullup_q <= hwdata[BIT_PULLUP];
  end

  // Interrupt enables, same layout as the status word.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      enable_q <= EVT_RESET;
    else if (ce && enable_wr)
      enable_q <= hwdata[EVT_W-1:0];
  end

  // Previous invert value, compared each clock to spot a change. Comparing
  // values rather than decoding writes means a rewrite of the same value is
  // not an event.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      invert_prev_q <= CTRL_RESET[BIT_INVERT];
    else if (ce)
      invert_prev_q <= result_invert_q;
  end

  // Event sources. An invert change counts even while disabled.
  // Flipping the invert bit also flips the adjusted result, so an enabled edge
  // detector may flag the same write a second time; both land in one flag.
  always_comb
  begin
    set_evt = '0;
    set_evt[BIT_CROSS] = (rise && rise_irq_en_q) || (fall && fall_irq_en_q);
    set_evt[BIT_POLCHG] = (result_invert_q != invert_prev_q);
    // A polarity change also sets the crossing flag, mirroring one shared flag.
    set_evt[BIT_CROSS] = set_evt[BIT_CROSS] || set_evt[BIT_POLCHG];
    clr_evt = '0;
    if (clear_wr)
      clr_evt = hwdata[EVT_W-1:0];
  end

  // Sticky status; set beats clear in the same cycle.
  // Software clears a flag by writing a one to its bit of the clear word; an
  // event arriving in the clearing cycle survives, so no crossing is lost
  // between the service routine's read and its clear.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      status_q <= EVT_RESET;
    else if (ce)
      status_q <= (status_q & ~clr_evt) | set_evt;
  end

  // Level interrupt while any enabled status bit is set.
  // It is computed from the next status value so that it drops on the same
  // edge as the flag that caused it, not one clock later.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irq <= 1'b0;
    else if (ce)
      irq <= |(((status_q & ~clr_evt) | set_evt) & enable_q);
  end

  // Read data is taken from the addressed register at the address phase edge, so it
  // stands for the whole data phase and is there when the master samples hready at
  // its close. Outside a read it returns to zero.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      hrdata <= '0;
    else if (ce)
    begin
      if (addr_phase && !hwrite)
        hrdata <= read_word(haddr[ADDR_W-1:0]);
      else
        hrdata <= 32'h0000_0000;
    end
  end

endmodule : zcd_top
`default_nettype wire

/* rtl/zcd_pkg.sv */
// Package with register map, field positions and reset values of the crossing detector.
package zcd_pkg;
  // Register byte addresses. The control word index is its printed offset.
  localparam logic [11:0] CTRL_INDEX = 12'h21f;
  localparam logic [13:0] ADDR_CTRL = {CTRL_INDEX, 2'b00};
  localparam logic [13:0] ADDR_STATUS = 14'h0000;
  localparam logic [13:0] ADDR_CLEAR = 14'h0004;
  localparam logic [13:0] ADDR_ENABLE = 14'h0008;
  localparam logic [13:0] ADDR_PINCFG = 14'h000c;
  localparam int ADDR_W = 14;
  // Control register field positions.
  localparam int BIT_SW_EN = 7;
  localparam int BIT_RESULT = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_RISE_EN = 1;
  localparam int BIT_FALL_EN = 0;
  // Status, clear and enable share this layout.
  localparam int BIT_CROSS = 0;
  localparam int BIT_POLCHG = 1;
  localparam int EVT_W = 2;
  // Pin configuration register: weak pull-up request.
  localparam int BIT_PULLUP = 0;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
  // AHB transfer encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : zcd_pkg

/* rtl/zcd_sync.sv */
// Two-stage synchroniser for one asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module zcd_sync (
  // Clock and control.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Level in and out.
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // The first stage feeds only the second, keeping metastability contained.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (ce)
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : zcd_sync
`default_nettype wire

/* rtl/zcd_edge.sv */
// Rise and fall detector on a synchronous level.
`timescale 1ns/1ps
`default_nettype none
module zcd_edge (
  // Clock and control.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Level and edge pulses.
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_q;

  // The previous level is held so edges compare against last cycle.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prev_q <= 1'b0;
    else if (ce)
      prev_q <= level;
  end

  // Two independent detectors.
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule : zcd_edge
`default_nettype wire

/* tb/ac_source.sv */
// Model of the external AC source seen through the series resistor.
`timescale 1ns/1ps
`default_nettype none
module ac_source #(
  parameter int DELAY_NS = 7
) (
  // Commanded source level.
  input wire logic above_cmd,
  // Comparator decision at the pin.
  output logic comp_above_ref
);
  // The decision settles after the crossing, unrelated in phase to the clock.
  initial comp_above_ref = 1'b0;
  always @(above_cmd) comp_above_ref <= #(DELAY_NS) above_cmd;
endmodule : ac_source
`default_nettype wire

/* tb/zcd_monitor.sv */
// Checker of the crossing detector port behaviour.
`timescale 1ns/1ps
`default_nettype none
module zcd_monitor (
  // Clock and control.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Bus.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Front end and results.
  input wire logic comp_above_ref,
  input wire logic cfg_fuse,
  input wire logic sink_active,
  input wire logic source_active,
  input wire logic detector_active,
  input wire logic crossing_out,
  input wire logic irq
);
  logic cmp_q;
  logic [2:0] wr_age_q;
  logic [2:0] cmp_age_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Ages of the last write and comparator change; reset zeroes them as it may move outputs too.
  always_ff @(posedge clk_sys)
  begin
    cmp_q <= comp_above_ref;
    if (rst || (hsel && hready && htrans == 2'h2 && hwrite))
      wr_age_q <= 3'h0;
    else if (wr_age_q != 3'h7)
      wr_age_q <= wr_age_q + 3'h1;
    if (rst || comp_above_ref != cmp_q)
      cmp_age_q <= 3'h0;
    else if (cmp_age_q != 3'h7)
      cmp_age_q <= cmp_age_q + 3'h1;
  end
  sequence above_s;
    ce && detector_active && comp_above_ref;
  endsequence
  sequence below_s;
    ce && detector_active && !comp_above_ref;
  endsequence
  bus_okay_a: assert property (!hresp && hreadyout)
    else $error("bus answer not ready or not okay");
  sink_excl_a: assert property (sink_active |-> !source_active)
    else $error("sink and source both active");
  sink_on_a: assert property (above_s [*5] |-> sink_active)
    else $error("sink missing above reference");
  source_on_a: assert property (below_s [*5] |-> source_active)
    else $error("source missing below reference");
  fuse_on_a: assert property ((ce && !cfg_fuse) [*5] |-> detector_active)
    else $error("detector off with fuse clear");
  idle_quiet_a: assert property (!detector_active [*2] |-> !sink_active && !source_active)
    else $error("pin driven while detector off");
  irq_hold_a: assert property ($fell(irq) |-> wr_age_q <= 3'h5)
    else $error("interrupt dropped without a write");
  out_cause_a: assert property ($changed(crossing_out) |-> wr_age_q <= 3'h5 || cmp_age_q <= 3'h5)
    else $error("result moved without cause");
endmodule : zcd_monitor
bind zcd_top zcd_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .ce(ce), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .comp_above_ref(comp_above_ref), .cfg_fuse(cfg_fuse), .sink_active(sink_active),
  .source_active(source_active), .detector_active(detector_active),
  .crossing_out(crossing_out), .irq(irq));
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the crossing detector.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import zcd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic cfg_fuse = 1'b1;
  logic above_cmd = 1'b0;
  logic comp_above_ref;
  logic sink_active;
  logic source_active;
  logic detector_active;
  logic pullup_request;
  logic crossing_out;
  logic irq;
  int bad_count = 0;
  int check_count = 0;
  // Half period of the 25 MHz clock.
  always #20 clk_sys = ~clk_sys;
  ac_source u_src (.above_cmd(above_cmd), .comp_above_ref(comp_above_ref));
  zcd_top dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_above_ref(comp_above_ref),
    .cfg_fuse(cfg_fuse), .sink_active(sink_active), .source_active(source_active),
    .detector_active(detector_active), .pullup_request(pullup_request),
    .crossing_out(crossing_out), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic pin(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : pin
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  // One single transfer; entered just after an edge, data taken at the closing edge.
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
    output logic [31:0] q);
    htrans <= HTRANS_NONSEQ;
    haddr <= {18'h0, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string n, input logic [13:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q & m);
  endtask : rdc
  task automatic t_regs;
    rdc("ctrl", ADDR_CTRL, 32'hff, {24'h0, CTRL_RESET});
    rdc("unmapped", 14'h0100, 32'hffffffff, 32'h0);
    // The pull-up is tried only while the detector is still off, then left disabled.
    wr(ADDR_PINCFG, 32'h1);
    wt(2);
    pin("pullup on", 1'b1, pullup_request);
    rdc("pincfg", ADDR_PINCFG, 32'h1, 32'h1);
    wr(ADDR_PINCFG, 32'h0);
    wt(2);
    pin("pullup", 1'b0, pullup_request);
    pin("off", 1'b0, detector_active);
    wr(ADDR_CTRL, 32'h83);
    wt(2);
    pin("on", 1'b1, detector_active);
    rdc("ctrl rw", ADDR_CTRL, 32'hb3, 32'h83);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_fuse;
    wr(ADDR_CTRL, 32'h03);
    wt(2);
    pin("sw off", 1'b0, detector_active);
    cfg_fuse <= 1'b0;
    wt(6);
    pin("fuse on", 1'b1, detector_active);
    $display("t_fuse done");
  endtask : t_fuse
  task automatic t_result;
    above_cmd <= 1'b1;
    wt(6);
    pin("sink", 1'b1, sink_active);
    pin("source", 1'b0, source_active);
    rdc("result", ADDR_CTRL, 32'h20, 32'h20);
    pin("out", 1'b1, crossing_out);
    wr(ADDR_CTRL, 32'h13);
    wt(2);
    rdc("inverted", ADDR_CTRL, 32'h20, 32'h0);
    pin("out inv", 1'b0, crossing_out);
    rdc("pol event", ADDR_STATUS, 32'h2, 32'h2);
    wr(ADDR_CLEAR, 32'h3);
    rdc("cleared", ADDR_STATUS, 32'h3, 32'h0);
    // The inverted rise reaches the flag at the very edge that closes the clear.
    above_cmd <= 1'b0;
    wt(1);
    wr(ADDR_CLEAR, 32'h3);
    rdc("set wins", ADDR_STATUS, 32'h1, 32'h1);
    above_cmd <= 1'b1;
    wt(6);
    $display("t_result done");
  endtask : t_result
  task automatic t_edges;
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_CTRL, 32'h02);
    wt(4);
    wr(ADDR_CLEAR, 32'h3);
    above_cmd <= 1'b0;
    wt(6);
    rdc("no fall", ADDR_STATUS, 32'h1, 32'h0);
    pin("irq low", 1'b0, irq);
    above_cmd <= 1'b1;
    wt(6);
    rdc("rise", ADDR_STATUS, 32'h1, 32'h1);
    pin("irq", 1'b1, irq);
    wt(20);
    pin("irq held", 1'b1, irq);
    wr(ADDR_CLEAR, 32'h1);
    wt(3);
    pin("irq clr", 1'b0, irq);
    wr(ADDR_CTRL, 32'h12);
    wt(4);
    wr(ADDR_CLEAR, 32'h3);
    above_cmd <= 1'b0;
    wt(6);
    rdc("inv rise", ADDR_STATUS, 32'h1, 32'h1);
    wr(ADDR_ENABLE, 32'h0);
    wt(3);
    pin("masked", 1'b0, irq);
    rdc("sticky", ADDR_STATUS, 32'h1, 32'h1);
    $display("t_edges done");
  endtask : t_edges
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // Main sequence after four reset cycles.
  initial
  begin
    wt(4);
    rst <= 1'b0;
    t_regs();
    t_fuse();
    t_result();
    t_edges();
    results();
  end
  // Watchdog well beyond the roughly 140 cycles the tests need.
  initial
  begin
    wt(5000);
    bad_count++;
    results();
  end
endmodule : tb_top
`default_nettype wire
